// [core/phd_pkg.sv]
package phd_pkg;
    // Link geometry
    localparam int HEAD_BITS = 64;
    localparam int DATA_BITS = 8;
    localparam int CHAIN_LEN = 8;
    localparam int SYNC_W = 15;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SHIFT_HALF_NS = 400;
    localparam int LATCH_PULSE_NS = 400;
    localparam int OSC_PERIOD_NS = 1250;
    localparam int SHIFT_HALF_CYC =
        (SHIFT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LATCH_PULSE_CYC =
        (LATCH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OSC_HALF_CYC = OSC_PERIOD_NS / 2 / CLK_PERIOD_NS;

    // Host register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h04;
    localparam logic [7:0] REG_CMD = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;

    // Control fields
    localparam int CTRL_SEL_BIT = 0;
    localparam int CTRL_EN_N_BIT = 1;
    localparam int CTRL_RST_N_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h6;
    localparam int CMD_LATCH_BIT = 0;

    // Status fields
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_EMPTY_BIT = 1;
    localparam int ST_SOUT_BIT = 2;
    localparam int ST_ONESHOT_BIT = 3;

    // Buffering
    localparam int FIFO_DEPTH = 8;

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [core/phd_link_if.sv]
`timescale 1ns/1ps
interface phd_link_if;
    logic shift_clk;
    logic [7:0] print_data_in;
    logic select_par;
    logic [1:0] latch_strobe_pair;
    logic reset_pin_n;
    logic enable_n;
    logic serial_out;
    logic [1:0] oneshot_timing_node;
    logic oneshot_out;
    logic [63:0] head_drive_outputs_o;
    logic [63:0] head_drive_outputs_oe;

    modport dev (
        input shift_clk,
        input print_data_in,
        input select_par,
        input latch_strobe_pair,
        input reset_pin_n,
        input enable_n,
        input oneshot_timing_node,
        output serial_out,
        output oneshot_out,
        output head_drive_outputs_o,
        output head_drive_outputs_oe
    );

    modport host (
        output shift_clk,
        output print_data_in,
        output select_par,
        output latch_strobe_pair,
        output reset_pin_n,
        output enable_n,
        input serial_out,
        input oneshot_out
    );
endinterface

// [core/phd_device.sv]
`timescale 1ns/1ps
module phd_device (
    input wire logic CLK,
    input wire logic RESET_N,
    phd_link_if.dev LNK,
    output logic [63:0] HEAD_ON
);
    typedef enum logic [1:0] {OS_IDLE, OS_ARM, OS_ACTIVE} phd_os_t;

    logic [phd_pkg::SYNC_W-1:0] raw;
    logic [phd_pkg::SYNC_W-1:0] s1_q;
    logic [phd_pkg::SYNC_W-1:0] s2_q;
    logic sck_prev_q;
    logic [7:0] din;
    logic sck;
    logic sel_par;
    logic [1:0] strobe;
    logic pin_rst_n;
    logic en_n;
    logic node_low;
    logic node_high;
    logic node_hi_s1_q;
    logic node_hi_s2_q;
    logic shift_rise;
    logic [phd_pkg::HEAD_BITS-1:0] sr_q;
    logic [phd_pkg::HEAD_BITS-1:0] latch1_q;
    logic [phd_pkg::HEAD_BITS-1:0] latch2_q;
    logic [phd_pkg::HEAD_BITS-1:0] head_on_q;
    logic [7:0] osc_cnt_q;
    logic osc_q;
    logic osc_rise;
    phd_os_t os_q;
    phd_os_t os_d;
    logic oneshot_q;
    logic sout_q;

    // Next shift register contents for either loading mode
    function automatic logic [63:0] shift_next(
        input logic [63:0] cur,
        input logic [7:0] d,
        input logic par
    );
        logic [63:0] nxt;
        nxt = {cur[62:0], d[0]};
        if (par) begin
            for (int k = 0; k < 8; k++) begin
                nxt[k*8 +: 8] = {cur[k*8 +: 7], d[k]};
            end
        end
        return nxt;
    endfunction

    // Pin bundle into the synchroniser
    assign raw = {LNK.oneshot_timing_node[0], LNK.enable_n, LNK.reset_pin_n,
                  LNK.latch_strobe_pair, LNK.select_par, LNK.shift_clk,
                  LNK.print_data_in};
    assign din = s2_q[7:0];
    assign sck = s2_q[8];
    assign sel_par = s2_q[9];
    assign strobe = s2_q[11:10];
    assign pin_rst_n = s2_q[12];
    assign en_n = s2_q[13];
    assign node_low = s2_q[14];
    assign node_high = node_hi_s2_q;

    // Two-flop synchroniser on every pin except oneshot_timing_node[1]
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    // Shift clock edge detect
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck;
        end
    end
    assign shift_rise = sck && !sck_prev_q;

    // Shift register
    always_ff @(posedge CLK) begin
        if (!RESET_N || !pin_rst_n) begin
            sr_q <= '0;
        end else if (shift_rise) begin
            sr_q <= shift_next(sr_q, din, sel_par);
        end
    end

    // First latch stage follows the register while strobed
    always_ff @(posedge CLK) begin
        if (!RESET_N || !pin_rst_n) begin
            latch1_q <= '0;
        end else if (strobe[0]) begin
            latch1_q <= sr_q;
        end
    end

    // Second latch stage follows the first while strobed
    always_ff @(posedge CLK) begin
        if (!RESET_N || !pin_rst_n) begin
            latch2_q <= '0;
        end else if (strobe[1]) begin
            latch2_q <= latch1_q;
        end
    end

    // Internal oscillator from a divider
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            osc_cnt_q <= 8'h00;
            osc_q <= 1'b0;
        end else if (osc_cnt_q ==
                     8'(phd_pkg::OSC_HALF_CYC - 1)) begin
            osc_cnt_q <= 8'h00;
            osc_q <= !osc_q;
        end else begin
            osc_cnt_q <= osc_cnt_q + 8'h01;
        end
    end
    assign osc_rise = (osc_cnt_q == 8'(phd_pkg::OSC_HALF_CYC - 1))
                      && !osc_q;

    // One-shot sequencing
    always_comb begin
        os_d = os_q;
        case (os_q)
            OS_IDLE: begin
                if (!en_n) begin
                    os_d = OS_ARM;
                end
            end
            OS_ARM: begin
                if (en_n) begin
                    os_d = OS_IDLE;
                end else if (osc_rise && node_low) begin
                    os_d = OS_ACTIVE;
                end
            end
            OS_ACTIVE: begin
                if (en_n || node_high) begin
                    os_d = OS_IDLE;
                end
            end
            default: begin
                os_d = OS_IDLE;
            end
        endcase
    end

    // Upper threshold pin through its own two flops
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            node_hi_s1_q <= 1'b0;
            node_hi_s2_q <= 1'b0;
        end else begin
            node_hi_s1_q <= LNK.oneshot_timing_node[1];
            node_hi_s2_q <= node_hi_s1_q;
        end
    end

    // One-shot state and its output
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            os_q <= OS_IDLE;
            oneshot_q <= 1'b1;
        end else begin
            os_q <= os_d;
            oneshot_q <= (os_d != OS_ACTIVE);
        end
    end

    // Output drive gated by enable and one-shot
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            head_on_q <= '0;
        end else if (!en_n && os_d == OS_ACTIVE) begin
            head_on_q <= latch2_q;
        end else begin
            head_on_q <= '0;
        end
    end

    // Serial readback of the last stage
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            sout_q <= 1'b0;
        end else begin
            sout_q <= sr_q[phd_pkg::HEAD_BITS-1];
        end
    end

    // Open-drain pins pull low while enabled
    assign LNK.head_drive_outputs_o = '0;
    assign LNK.head_drive_outputs_oe = head_on_q;
    assign LNK.serial_out = sout_q;
    assign LNK.oneshot_out = oneshot_q;
    assign HEAD_ON = head_on_q;
endmodule

// [core/phd_host.sv]
`timescale 1ns/1ps
// Byte buffer between bus writes and the shift engine
module phd_fifo #(
    parameter int W = 8,
    parameter int DEPTH = phd_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// Host controller: AXI4-Lite registers to print-head link
module phd_host (
    input wire logic CLK,
    input wire logic RESET_N,
    phd_link_if.host LNK,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    typedef enum logic [1:0] {E_IDLE, E_LO, E_HI, E_LATCH} phd_eng_t;

    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_got_q, w_got_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic [2:0] ctrl_q;
    logic latch_pend_q;
    logic [1:0] in_s1_q, in_s2_q;
    phd_eng_t eng_q;
    logic [7:0] cnt_q;
    logic sck_q;
    logic [7:0] data_q;
    logic [1:0] strobe_q;
    logic is_data, wr_fire, fifo_in_ready, fifo_out_valid, latch_start;
    logic [7:0] fifo_out_data;
    logic busy;

    // Write executes once both address and data are held and, for DATA, the FIFO has room
    assign is_data = (awaddr_q == phd_pkg::REG_DATA);
    assign wr_fire = aw_got_q && w_got_q && !bvalid_q
                     && (!is_data || fifo_in_ready);
    assign latch_start = (eng_q == E_IDLE) && !fifo_out_valid
                         && latch_pend_q;
    assign busy = (eng_q != E_IDLE) || fifo_out_valid || latch_pend_q;

    phd_fifo #(.W(8), .DEPTH(phd_pkg::FIFO_DEPTH)) u_fifo (
        .clk(CLK),
        .reset_n(RESET_N),
        .in_valid(wr_fire && is_data),
        .in_ready(fifo_in_ready),
        .in_data(wdata_q[7:0]),
        .out_valid(fifo_out_valid),
        .out_ready(eng_q == E_IDLE),
        .out_data(fifo_out_data)
    );

    // Write address and data channels, then response
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            bvalid_q <= 1'b0;
            bresp_q <= phd_pkg::RESP_OKAY;
        end else begin
            if (S_AXI_AWVALID && awready_q) begin
                awready_q <= 1'b0;
                aw_got_q <= 1'b1;
                awaddr_q <= {S_AXI_AWADDR[7:2], 2'h0};
            end
            if (S_AXI_WVALID && wready_q) begin
                wready_q <= 1'b0;
                w_got_q <= 1'b1;
                wdata_q <= S_AXI_WDATA;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= (awaddr_q == phd_pkg::REG_STATUS
                            || awaddr_q > phd_pkg::REG_STATUS)
                           ? phd_pkg::RESP_SLVERR : phd_pkg::RESP_OKAY;
            end
            if (bvalid_q && S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Control register steering the link pins
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            ctrl_q <= phd_pkg::CTRL_RESET;
        end else if (wr_fire && awaddr_q == phd_pkg::REG_CTRL) begin
            ctrl_q <= wdata_q[2:0];
        end
    end

    // Latch request; a new request wins over its clear
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            latch_pend_q <= 1'b0;
        end else if (wr_fire && awaddr_q == phd_pkg::REG_CMD
                     && wdata_q[phd_pkg::CMD_LATCH_BIT]) begin
            latch_pend_q <= 1'b1;
        end else if (latch_start) begin
            latch_pend_q <= 1'b0;
        end
    end

    // Synchronise readback pins
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            in_s1_q <= 2'h0;
            in_s2_q <= 2'h0;
        end else begin
            in_s1_q <= {LNK.oneshot_out, LNK.serial_out};
            in_s2_q <= in_s1_q;
        end
    end

    // Read channel, answered one cycle after the address
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= phd_pkg::RESP_OKAY;
        end else if (S_AXI_ARVALID && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= phd_pkg::RESP_OKAY;
            rdata_q <= 32'h0;
            case ({S_AXI_ARADDR[7:2], 2'h0})
                phd_pkg::REG_CTRL: rdata_q <= {29'h0, ctrl_q};
                phd_pkg::REG_DATA: rdata_q <= 32'h0;
                phd_pkg::REG_CMD: rdata_q <= {31'h0, latch_pend_q};
                phd_pkg::REG_STATUS: begin
                    rdata_q[phd_pkg::ST_BUSY_BIT] <= busy;
                    rdata_q[phd_pkg::ST_EMPTY_BIT] <= !fifo_out_valid;
                    rdata_q[phd_pkg::ST_SOUT_BIT] <= in_s2_q[0];
                    rdata_q[phd_pkg::ST_ONESHOT_BIT] <= in_s2_q[1];
                end
                default: rresp_q <= phd_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Shift and latch engine
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            eng_q <= E_IDLE;
            cnt_q <= 8'h00;
            sck_q <= 1'b0;
            data_q <= 8'h00;
            strobe_q <= 2'h0;
        end else begin
            case (eng_q)
                E_IDLE: begin
                    if (fifo_out_valid) begin
                        data_q <= fifo_out_data;
                        cnt_q <= 8'(phd_pkg::SHIFT_HALF_CYC - 1);
                        eng_q <= E_LO;
                    end else if (latch_pend_q) begin
                        strobe_q <= 2'h3;
                        cnt_q <= 8'(phd_pkg::LATCH_PULSE_CYC - 1);
                        eng_q <= E_LATCH;
                    end
                end
                E_LO: begin
                    if (cnt_q == 8'h00) begin
                        sck_q <= 1'b1;
                        cnt_q <= 8'(phd_pkg::SHIFT_HALF_CYC - 1);
                        eng_q <= E_HI;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                E_HI: begin
                    if (cnt_q == 8'h00) begin
                        sck_q <= 1'b0;
                        eng_q <= E_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                E_LATCH: begin
                    if (cnt_q == 8'h00) begin
                        strobe_q <= 2'h0;
                        eng_q <= E_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    eng_q <= E_IDLE;
                end
            endcase
        end
    end

    // Link pins straight from flops
    assign LNK.shift_clk = sck_q;
    assign LNK.print_data_in = data_q;
    assign LNK.latch_strobe_pair = strobe_q;
    assign LNK.select_par = ctrl_q[phd_pkg::CTRL_SEL_BIT];
    assign LNK.enable_n = ctrl_q[phd_pkg::CTRL_EN_N_BIT];
    assign LNK.reset_pin_n = ctrl_q[phd_pkg::CTRL_RST_N_BIT];
    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
endmodule

// [verification/phd_chk.sv]
`timescale 1ns/1ps
// Link checker between host and device ends
module phd_chk (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic shift_clk,
    input wire logic [7:0] print_data_in,
    input wire logic select_par,
    input wire logic [1:0] latch_strobe_pair,
    input wire logic enable_n,
    input wire logic [1:0] oneshot_timing_node,
    input wire logic oneshot_out,
    input wire logic [63:0] head_drive_outputs_o,
    input wire logic [63:0] head_drive_outputs_oe
);
    // Single clock domain
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    // Device pins only pull low
    a_drain_only_low: assert property (
        head_drive_outputs_o == 64'h0)
        else $error("output pin data driven high");
    // Enable high keeps every dot off
    a_off_while_disabled: assert property (
        enable_n [*6] |-> head_drive_outputs_oe == 64'h0)
        else $error("dot on while disabled");
    // Dots only on inside the one-shot period
    a_oneshot_bounds_on: assert property (
        oneshot_out [*2] |-> head_drive_outputs_oe == 64'h0)
        else $error("dot on outside one-shot period");
    // One-shot only fires with enable low
    a_fire_needs_enable: assert property (
        $fell(oneshot_out) |-> $past(enable_n, 3) == 1'b0)
        else $error("one-shot fired while disabled");
    // Node above upper threshold ends the period
    a_upper_ends_pulse: assert property (
        oneshot_timing_node[1] [*6] |-> oneshot_out)
        else $error("one-shot not ended by node");
    // Shift clock high for four cycles
    a_shift_high_width: assert property (
        $rose(shift_clk) |-> shift_clk [*4] ##1 !shift_clk)
        else $error("shift clock high width wrong");
    // Data and mode steady while shift clock high
    a_data_steady: assert property (
        shift_clk |-> $stable(print_data_in) && $stable(select_par))
        else $error("data moved during shift");
    // Both strobes high four cycles then low
    a_strobe_width: assert property (
        $rose(latch_strobe_pair == 2'h3) |->
        (latch_strobe_pair == 2'h3) [*4] ##1 latch_strobe_pair == 2'h0)
        else $error("latch strobe width wrong");
    // No latching during a shift
    a_latch_not_shift: assert property (
        latch_strobe_pair != 2'h0 |-> !shift_clk)
        else $error("latch strobe during shift");
endmodule

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
    localparam logic [63:0] PAT_S = 64'hc3a50f817e249bd6;
    localparam logic [63:0] PAT_P = 64'h123456789abcdef0;
    logic clk;
    logic reset_n;
    logic [7:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    logic [1:0] resp;
    logic [31:0] rd;
    logic [63:0] head_on;
    logic [63:0] head_pin;
    int n_errors;
    int comparisons;
    int cycles;

    phd_link_if lnk ();
    // Open-drain wire with pull-up: low where enabled
    assign head_pin = ~lnk.head_drive_outputs_oe | lnk.head_drive_outputs_o;

    phd_device phd_device_inst (.CLK(clk), .RESET_N(reset_n), .LNK(lnk),
        .HEAD_ON(head_on));
    phd_host phd_host_inst (.CLK(clk), .RESET_N(reset_n), .LNK(lnk),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    phd_chk phd_chk_inst (.CLK(clk), .RESET_N(reset_n),
        .shift_clk(lnk.shift_clk), .print_data_in(lnk.print_data_in),
        .select_par(lnk.select_par),
        .latch_strobe_pair(lnk.latch_strobe_pair),
        .enable_n(lnk.enable_n),
        .oneshot_timing_node(lnk.oneshot_timing_node),
        .oneshot_out(lnk.oneshot_out),
        .head_drive_outputs_o(lnk.head_drive_outputs_o),
        .head_drive_outputs_oe(lnk.head_drive_outputs_oe));

    // Clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            n_errors++;
            results();
        end
    end

    task results;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task chk(input logic [63:0] g, input logic [63:0] e);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Bus write, answer code left in resp
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1)
            @(posedge clk);
        resp = bresp;
        bready <= 1'b0;
    endtask

    // Bus read into rd and resp
    task rd_reg(input logic [7:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1)
            @(posedge clk);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task wait_idle;
        rd = 32'h1;
        while (rd[phd_pkg::ST_BUSY_BIT] !== 1'b0
            || rd[phd_pkg::ST_EMPTY_BIT] !== 1'b1)
            rd_reg(phd_pkg::REG_STATUS);
    endtask

    task latch;
        wr(phd_pkg::REG_CMD, 32'h1);
        do rd_reg(phd_pkg::REG_CMD); while (rd[0] !== 1'b0);
        wait_idle();
    endtask

    // Serial bytes carry junk above bit 0
    task push_ser(input logic [63:0] p);
        for (int i = 0; i < 64; i++) begin
            wr(phd_pkg::REG_DATA, {24'h0, 7'h55, p[63 - i]});
        end
        wait_idle();
    endtask

    task push_par(input logic [63:0] q);
        logic [7:0] b;
        for (int m = 0; m < 8; m++) begin
            for (int k = 0; k < 8; k++) begin
                b[k] = q[8 * k + 7 - m];
            end
            wr(phd_pkg::REG_DATA, {24'h0, b});
        end
        wait_idle();
    endtask

    // Enable, fire one-shot, compare dots, end pulse
    task fire(input logic sel, input logic [63:0] e);
        repeat (2 * phd_pkg::OSC_HALF_CYC) @(posedge clk);
        lnk.oneshot_timing_node <= 2'h1;
        wr(phd_pkg::REG_CTRL, {29'h0, 1'b1, 1'b0, sel});
        while (lnk.oneshot_out !== 1'b0)
            @(posedge clk);
        repeat (3) @(posedge clk);
        chk(head_pin, ~e);
        chk(head_on, e);
        rd_reg(phd_pkg::REG_STATUS);
        chk(64'(rd[phd_pkg::ST_ONESHOT_BIT]), 64'h0);
        lnk.oneshot_timing_node <= 2'h2;
        while (lnk.oneshot_out !== 1'b1)
            @(posedge clk);
        repeat (6) @(posedge clk);
        chk(lnk.head_drive_outputs_oe, 64'h0);
        lnk.oneshot_timing_node <= 2'h0;
        wr(phd_pkg::REG_CTRL, {29'h0, 1'b1, 1'b1, sel});
    endtask

    task t_regs;
        chk(lnk.head_drive_outputs_oe, 64'h0);
        rd_reg(phd_pkg::REG_CTRL);
        chk(64'(rd), 64'(phd_pkg::CTRL_RESET));
        wr(8'h40, 32'h1);
        chk(64'(resp), 64'(phd_pkg::RESP_SLVERR));
        wr(phd_pkg::REG_STATUS, 32'hf);
        chk(64'(resp), 64'(phd_pkg::RESP_SLVERR));
        rd_reg(8'h40);
        chk({30'h0, resp, rd}, {30'h0, phd_pkg::RESP_SLVERR, 32'h0});
        $display("register test done");
    endtask

    task t_serial;
        push_ser(PAT_S);
        chk(64'(lnk.serial_out), 64'(PAT_S[63]));
        rd_reg(phd_pkg::REG_STATUS);
        chk(64'(rd[phd_pkg::ST_SOUT_BIT]), 64'(PAT_S[63]));
        latch();
        fire(1'b0, PAT_S);
        $display("serial test done");
    endtask

    task t_parallel;
        wr(phd_pkg::REG_CTRL, 32'h7);
        push_par(PAT_P);
        latch();
        fire(1'b1, PAT_P);
        push_par(~PAT_P);
        fire(1'b1, PAT_P);
        latch();
        fire(1'b1, ~PAT_P);
        $display("parallel test done");
    endtask

    task t_pin_reset;
        wr(phd_pkg::REG_CTRL, 32'h2);
        repeat (8) @(posedge clk);
        wr(phd_pkg::REG_CTRL, 32'h6);
        repeat (4) @(posedge clk);
        chk(64'(lnk.serial_out), 64'h0);
        fire(1'b0, 64'h0);
        $display("pin reset test done");
    endtask

    // Main sequence
    initial begin
        reset_n = 1'b0;
        awaddr = 8'h0;
        awvalid = 1'b0;
        wdata = 32'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h0;
        arvalid = 1'b0;
        rready = 1'b0;
        lnk.oneshot_timing_node = 2'h0;
        n_errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_serial();
        t_parallel();
        t_pin_reset();
        results();
    end
endmodule
